// ===== hdl/timer_pkg.sv
// Register map, bit positions and timing counts of the capture/reload timer
package timer_pkg;
  localparam int ADDR_W = 3;
  localparam logic [2:0] ADDR_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_COUNT_LOW = 3'h1;
  localparam logic [2:0] ADDR_COUNT_HIGH = 3'h2;
  localparam logic [2:0] ADDR_CAPTURE_LOW = 3'h3;
  localparam logic [2:0] ADDR_CAPTURE_HIGH = 3'h4;
  localparam logic [2:0] ADDR_MODE_EXT = 3'h5;
  localparam logic [2:0] ADDR_POWER_CONTROL = 3'h6;
  localparam logic [2:0] ADDR_INT_ENABLE = 3'h7;
  // timer_control bit positions
  localparam int CTL_OVERFLOW = 7;
  localparam int CTL_EXT_EVENT = 6;
  localparam int CTL_RX_SRC = 5;
  localparam int CTL_TX_SRC = 4;
  localparam int CTL_EXT_TRIG_EN = 3;
  localparam int CTL_RUN = 2;
  localparam int CTL_CT_SEL = 1;
  localparam int CTL_CAP_RL = 0;
  // power_control bit positions
  localparam int PWR_RX_SRC_B = 5;
  localparam int PWR_TX_SRC_B = 4;
  // mode_extension and int_enable bit positions
  localparam int MODE_DOWN_EN = 0;
  localparam int INTEN_TIMER = 0;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  // Clocks per machine-cycle tick
  localparam int MACHINE_DIV = 12;
endpackage

// ===== hdl/capture_reload_timer.sv
// 16-bit capture / auto-reload / baud generator timer with register port
// What this block does
// - Count machine ticks when counter select clear, count pin falling edges when set.
// - Counting and all mode actions happen only while run control is one.
// - Capture mode without trigger enable is a 16-bit up counter setting overflow.
// - Capture mode with trigger enable copies count to capture on trigger falling edge.
// - Trigger-caused capture or reload sets external event flag; software clears it.
// - Overflow sets overflow flag until cleared; never in baud generator mode.
// - Auto-reload up-count rollover sets overflow and reloads count from capture registers.
// - Auto-reload with trigger enable also reloads on trigger falling edge.
// - Any receive or transmit baud source bit selects baud generator mode.
// - Receive source bit routes timer overflow to port A receive clock.
// - Transmit source bit routes timer overflow to port A transmit clock.
// - Baud mode ignores capture/reload select and always reloads on overflow.
// - In baud mode trigger edges only set the external event flag.
// - With trigger enable clear trigger pin falls are ignored; a low pin still selects down count in auto-reload.
// - Interrupt requested when either flag set and timer interrupt enabled.
// - Second source bit pair in power control clocks port B.
`timescale 1ns/1ps
module capture_reload_timer #(
  parameter int TICK_DIV = timer_pkg::MACHINE_DIV
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [timer_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  input wire logic count_input_pin,
  input wire logic trigger_pin,
  input wire logic other_timer_ovf,
  output logic rx_clk_a,
  output logic tx_clk_a,
  output logic rx_clk_b,
  output logic tx_clk_b,
  output logic timer_irq
);
  localparam int DIV_W = $clog2(TICK_DIV + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);

  logic [15:0] count_r, count_nxt;
  logic [15:0] capture_r, capture_nxt;
  logic [5:0] ctl_r;
  logic overflow_flag_r, ext_event_flag_r;
  logic rx_src_b_r, tx_src_b_r, down_en_r, int_en_r;
  logic [DIV_W-1:0] div_r;
  logic div_pulse_r, cnt_pin_prev_r, trig_prev_r;
  logic [7:0] rd_data_r;
  logic rx_clk_a_r, tx_clk_a_r, rx_clk_b_r, tx_clk_b_r, irq_r;

  // Register decode
  wire wr_ctl = wr_en && addr == timer_pkg::ADDR_CONTROL;
  wire wr_cl = wr_en && addr == timer_pkg::ADDR_COUNT_LOW;
  wire wr_ch = wr_en && addr == timer_pkg::ADDR_COUNT_HIGH;
  wire wr_pl = wr_en && addr == timer_pkg::ADDR_CAPTURE_LOW;
  wire wr_ph = wr_en && addr == timer_pkg::ADDR_CAPTURE_HIGH;
  wire wr_mode = wr_en && addr == timer_pkg::ADDR_MODE_EXT;
  wire wr_pwr = wr_en && addr == timer_pkg::ADDR_POWER_CONTROL;
  wire wr_ien = wr_en && addr == timer_pkg::ADDR_INT_ENABLE;
  wire cnt_wr = wr_cl || wr_ch;
  wire cap_wr = wr_pl || wr_ph;

  wire rx_src_a = ctl_r[timer_pkg::CTL_RX_SRC];
  wire tx_src_a = ctl_r[timer_pkg::CTL_TX_SRC];
  wire exen = ctl_r[timer_pkg::CTL_EXT_TRIG_EN];
  wire run = ctl_r[timer_pkg::CTL_RUN];
  wire ct_sel = ctl_r[timer_pkg::CTL_CT_SEL];
  wire cap_rl = ctl_r[timer_pkg::CTL_CAP_RL];

  wire baud = rx_src_a || tx_src_a || rx_src_b_r || tx_src_b_r;
  wire cnt_fall = cnt_pin_prev_r && !count_input_pin;
  wire trig_fall = trig_prev_r && !trigger_pin;
  wire tick = ct_sel ? cnt_fall : div_pulse_r;
  wire step = run && tick;
  wire trig_act = run && exen && trig_fall;
  wire capture_mode = cap_rl && !baud;
  wire down = !baud && !cap_rl && down_en_r && !trigger_pin;
  wire ovf_up = step && !down && count_r == timer_pkg::COUNT_MAX;
  wire ovf_dn = step && down && count_r == capture_r;
  // Reload on rollover outside capture mode, or on trigger edge outside capture and baud modes
  wire reload_ev = !capture_mode && (ovf_up || (!baud && trig_act));
  wire do_capture = capture_mode && trig_act;
  wire ovf_set = (ovf_up || ovf_dn) && !baud;
  wire ext_set = trig_act;

  always_comb
  begin
    count_nxt = count_r;
    if (wr_cl)
      count_nxt[7:0] = wr_data;
    else if (wr_ch)
      count_nxt[15:8] = wr_data;
    else if (reload_ev)
      count_nxt = capture_r;
    else if (ovf_dn)
      count_nxt = timer_pkg::COUNT_MAX;
    else if (step && down)
      count_nxt = count_r - 16'h0001;
    else if (step)
      count_nxt = count_r + 16'h0001;
  end

  always_comb
  begin
    capture_nxt = capture_r;
    if (wr_pl)
      capture_nxt[7:0] = wr_data;
    else if (wr_ph)
      capture_nxt[15:8] = wr_data;
    else if (do_capture)
      capture_nxt = count_r;
  end

  // Set wins over a software write of the same flag
  wire ovf_flag_nxt = ovf_set ||
    (wr_ctl ? wr_data[timer_pkg::CTL_OVERFLOW] : overflow_flag_r);
  wire ext_flag_nxt = ext_set ||
    (wr_ctl ? wr_data[timer_pkg::CTL_EXT_EVENT] : ext_event_flag_r);
  wire irq_nxt = (ovf_flag_nxt || ext_flag_nxt) && int_en_r;

  wire [7:0] ctl_view = {overflow_flag_r, ext_event_flag_r, ctl_r};
  wire [7:0] rd_mux =
    addr == timer_pkg::ADDR_CONTROL ? ctl_view :
    addr == timer_pkg::ADDR_COUNT_LOW ? count_r[7:0] :
    addr == timer_pkg::ADDR_COUNT_HIGH ? count_r[15:8] :
    addr == timer_pkg::ADDR_CAPTURE_LOW ? capture_r[7:0] :
    addr == timer_pkg::ADDR_CAPTURE_HIGH ? capture_r[15:8] :
    addr == timer_pkg::ADDR_MODE_EXT ? {7'h00, down_en_r} :
    addr == timer_pkg::ADDR_POWER_CONTROL ? {2'h0, rx_src_b_r, tx_src_b_r, 4'h0} :
    {7'h00, int_en_r};

  // Machine-cycle tick divider
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      div_r <= '0;
      div_pulse_r <= 1'b0;
    end
    else
    begin
      div_pulse_r <= div_r == DIV_LAST;
      div_r <= div_r == DIV_LAST ? '0 : div_r + DIV_W'(1);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      cnt_pin_prev_r <= 1'b1;
      trig_prev_r <= 1'b1;
      count_r <= {timer_pkg::RESET_BYTE, timer_pkg::RESET_BYTE};
      capture_r <= {timer_pkg::RESET_BYTE, timer_pkg::RESET_BYTE};
      overflow_flag_r <= 1'b0;
      ext_event_flag_r <= 1'b0;
    end
    else
    begin
      cnt_pin_prev_r <= count_input_pin;
      trig_prev_r <= trigger_pin;
      count_r <= count_nxt;
      capture_r <= capture_nxt;
      overflow_flag_r <= ovf_flag_nxt;
      ext_event_flag_r <= ext_flag_nxt;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ctl_r <= timer_pkg::RESET_BYTE[5:0];
      rx_src_b_r <= 1'b0;
      tx_src_b_r <= 1'b0;
      down_en_r <= 1'b0;
      int_en_r <= 1'b0;
    end
    else
    begin
      if (wr_ctl)
        ctl_r <= wr_data[5:0];
      if (wr_pwr)
      begin
        rx_src_b_r <= wr_data[timer_pkg::PWR_RX_SRC_B];
        tx_src_b_r <= wr_data[timer_pkg::PWR_TX_SRC_B];
      end
      if (wr_mode)
        down_en_r <= wr_data[timer_pkg::MODE_DOWN_EN];
      if (wr_ien)
        int_en_r <= wr_data[timer_pkg::INTEN_TIMER];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      rd_data_r <= timer_pkg::RESET_BYTE;
      rx_clk_a_r <= 1'b0;
      tx_clk_a_r <= 1'b0;
      rx_clk_b_r <= 1'b0;
      tx_clk_b_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else
    begin
      rd_data_r <= rd_en ? rd_mux : timer_pkg::RESET_BYTE;
      rx_clk_a_r <= rx_src_a ? ovf_up : other_timer_ovf;
      tx_clk_a_r <= tx_src_a ? ovf_up : other_timer_ovf;
      rx_clk_b_r <= rx_src_b_r ? ovf_up : other_timer_ovf;
      tx_clk_b_r <= tx_src_b_r ? ovf_up : other_timer_ovf;
      irq_r <= irq_nxt;
    end
  end

  assign rd_data = rd_data_r;
  assign rx_clk_a = rx_clk_a_r;
  assign tx_clk_a = tx_clk_a_r;
  assign rx_clk_b = rx_clk_b_r;
  assign tx_clk_b = tx_clk_b_r;
  assign timer_irq = irq_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_timer_tick;
    run && !ct_sel && div_pulse_r && !down && !cnt_wr && !reload_ev
      |=> count_r == $past(count_r) + 16'h0001;
  endproperty
  a_timer_tick: assert property (p_timer_tick) else $error("timer tick not counted");

  property p_stopped;
    !run && !cnt_wr |=> count_r == $past(count_r);
  endproperty
  a_stopped: assert property (p_stopped) else $error("count moved while stopped");

  property p_ovf_flag;
    ovf_up && !baud |=> overflow_flag_r;
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set");

  property p_capture;
    do_capture && !cap_wr |=> capture_r == $past(count_r);
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong");

  property p_ext_flag;
    trig_act |=> ext_event_flag_r;
  endproperty
  a_ext_flag: assert property (p_ext_flag) else $error("event flag not set");

  property p_no_ovf_baud;
    baud && !overflow_flag_r && !wr_ctl |=> !overflow_flag_r;
  endproperty
  a_no_ovf_baud: assert property (p_no_ovf_baud) else $error("overflow set in baud mode");

  property p_reload;
    !capture_mode && ovf_up && !cnt_wr |=> count_r == $past(capture_r);
  endproperty
  a_reload: assert property (p_reload) else $error("reload value wrong");

  property p_baud_keep_capture;
    baud && trig_act && !cap_wr |=> capture_r == $past(capture_r);
  endproperty
  a_baud_keep_capture: assert property (p_baud_keep_capture)
    else $error("capture moved in baud mode");

  property p_ignore_trig;
    !exen && !wr_ctl && !ext_event_flag_r |=> !ext_event_flag_r;
  endproperty
  a_ignore_trig: assert property (p_ignore_trig) else $error("trigger not ignored");

  property p_irq;
    (overflow_flag_r || ext_event_flag_r) && int_en_r && !wr_ctl && !wr_ien |=> timer_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_rx_clk;
    rx_src_a && ovf_up |=> rx_clk_a;
  endproperty
  a_rx_clk: assert property (p_rx_clk) else $error("receive clock missing");

  property p_down;
    step && down && !ovf_dn && !cnt_wr |=> count_r == $past(count_r) - 16'h0001;
  endproperty
  a_down: assert property (p_down) else $error("down count wrong");

  property p_trig_reload;
    trig_act && !capture_mode && !baud && !cnt_wr |=> count_r == $past(capture_r);
  endproperty
  a_trig_reload: assert property (p_trig_reload) else $error("trigger reload wrong");

  property p_tx_clk;
    tx_src_a && ovf_up |=> tx_clk_a;
  endproperty
  a_tx_clk: assert property (p_tx_clk) else $error("transmit clock missing");

  property p_rx_clk_b;
    rx_src_b_r && ovf_up |=> rx_clk_b;
  endproperty
  a_rx_clk_b: assert property (p_rx_clk_b) else $error("port B receive clock missing");

  c_capture: cover property (do_capture);
  c_reload_trig: cover property (reload_ev && trig_act);
  c_baud_clk: cover property (baud && ovf_up ##1 tx_clk_a);
  c_down_wrap: cover property (ovf_dn);
endmodule

// ===== sim/pin_model.sv
// Far-side pin model: count and trigger pins, idle high
`timescale 1ns/1ps
module pin_model (
  input wire logic ref_clk,
  input wire logic go_cnt,
  input wire logic go_trig,
  output logic count_input_pin,
  output logic trigger_pin
);
  logic [1:0] low_cnt = 2'h0;
  logic [1:0] low_trig = 2'h0;
  // Pin held low three cycles, one fall per request
  always @(posedge ref_clk)
  begin
    low_cnt <= go_cnt ? 2'h3 : low_cnt - 2'(low_cnt != 2'h0);
    low_trig <= go_trig ? 2'h3 : low_trig - 2'(low_trig != 2'h0);
  end
  assign count_input_pin = (low_cnt == 2'h0);
  assign trigger_pin = (low_trig == 2'h0);
endmodule

// ===== sim/tb.sv
// Self-checking bench of the capture/reload timer against a byte model
`timescale 1ns/1ps
module tb;
  logic ref_clk, rst_n, wr_en, rd_en, go_cnt, go_trig, other_timer_ovf, timer_irq;
  logic rx_clk_a, tx_clk_a, rx_clk_b, tx_clk_b, count_input_pin, trigger_pin;
  logic [2:0] addr;
  logic [7:0] wr_data, rd_data, b;
  logic [7:0] m_reg [8] = '{default: 8'h00};
  int n_fail, checked, cyc, n_bclk, m_bclk;
  capture_reload_timer #(.TICK_DIV(2)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .count_input_pin(count_input_pin), .trigger_pin(trigger_pin),
    .other_timer_ovf(other_timer_ovf), .rx_clk_a(rx_clk_a), .tx_clk_a(tx_clk_a),
    .rx_clk_b(rx_clk_b), .tx_clk_b(tx_clk_b), .timer_irq(timer_irq));
  pin_model u_pins (.ref_clk(ref_clk), .go_cnt(go_cnt), .go_trig(go_trig),
    .count_input_pin(count_input_pin), .trigger_pin(trigger_pin));
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    m_reg[a] = d & ((a == 3'h5 || a == 3'h7) ? 8'h01 : (a == 3'h6) ? 8'h30 : 8'hFF);
  endtask
  task rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask
  task verify();
    for (int a = 0; a < 8; a++)
    begin
      rd(3'(a), b);
      chk({8'h00, b}, {8'h00, m_reg[a]});
    end
    chk(16'(timer_irq), 16'((m_reg[0][7] | m_reg[0][6]) & m_reg[7][0]));
  endtask
  // One fall on the count or trigger pin, then the model reacts
  task pin_edge(input logic trig);
    logic bd;
    logic [15:0] c, p;
    bd = |{m_reg[0][5:4], m_reg[6][5:4]};
    c = {m_reg[2], m_reg[1]};
    p = {m_reg[4], m_reg[3]};
    @(posedge ref_clk);
    {go_trig, go_cnt} <= {trig, !trig};
    @(posedge ref_clk);
    {go_trig, go_cnt} <= 2'b00;
    repeat (6) @(posedge ref_clk);
    if (!m_reg[0][2])
      return;
    if (trig && m_reg[0][3])
    begin
      m_reg[0][6] = 1'b1;
      if (!bd)
        {c, p} = m_reg[0][0] ? {c, c} : {p, p};
    end
    else if (!trig && m_reg[0][1] && c == 16'hFFFF)
    begin
      m_bclk += {m_reg[6][4], m_reg[6][5], m_reg[0][4], m_reg[0][5]};
      m_reg[0][7] |= !bd;
      c = (bd || !m_reg[0][0]) ? p : 16'h0000;
    end
    else if (!trig && m_reg[0][1])
      c++;
    {m_reg[2], m_reg[1], m_reg[4], m_reg[3]} = {c, p};
  endtask
  task print_verdict();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Baud pulses weighted per output so a swapped route shows; ceiling cuts a hang
  always @(posedge ref_clk)
  begin
    cyc++;
    n_bclk += rx_clk_a + 2 * tx_clk_a + 4 * rx_clk_b + 8 * tx_clk_b;
    if (cyc == 20000)
    begin
      n_fail++;
      print_verdict();
    end
  end
  initial
  begin
    void'($urandom(32'h7762914A));
    {rst_n, wr_en, rd_en, go_cnt, go_trig, other_timer_ovf, addr, wr_data} = 17'h00000;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    verify();
    for (int a = 1; a < 8; a++)
      wr(3'(a), 8'($urandom));
    verify();
    wr(3'h5, 8'h00);
    wr(3'h6, 8'h00);
    wr(3'h7, 8'h01);
    // Capture after counted edges, rollover, then stopped and disabled trigger
    wr(3'h0, 8'h0F);
    repeat (3) pin_edge(1'b0);
    pin_edge(1'b1);
    verify();
    wr(3'h1, 8'hFF);
    wr(3'h2, 8'hFF);
    pin_edge(1'b0);
    wr(3'h0, 8'h0B);
    pin_edge(1'b0);
    pin_edge(1'b1);
    wr(3'h0, 8'h07);
    pin_edge(1'b1);
    verify();
    // Auto-reload on rollover, then on a trigger fall
    wr(3'h0, 8'h0E);
    wr(3'h1, 8'hFE);
    wr(3'h2, 8'hFF);
    repeat (2) pin_edge(1'b0);
    verify();
    wr(3'h1, 8'h10);
    pin_edge(1'b1);
    verify();
    // Every baud source pattern: own rollover, then the other timer
    for (int s = 0; s < 16; s++)
    begin
      wr(3'h6, {2'b00, 2'(s >> 2), 4'h0});
      wr(3'h0, {2'b00, 2'(s), 4'hE});
      wr(3'h1, 8'hFF);
      wr(3'h2, 8'hFF);
      pin_edge(1'b0);
      pin_edge(1'b1);
      other_timer_ovf <= 1'b1;
      @(posedge ref_clk);
      other_timer_ovf <= 1'b0;
      m_bclk += 15 - {m_reg[6][4], m_reg[6][5], m_reg[0][4], m_reg[0][5]};
      verify();
    end
    chk(16'(n_bclk), 16'(m_bclk));
    // Internal ticks, one per two clocks with the short divider
    wr(3'h6, 8'h00);
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h00);
    wr(3'h0, 8'h04);
    repeat (40) @(posedge ref_clk);
    wr(3'h0, 8'h00);
    rd(3'h1, b);
    // 42 running cycles, one tick every two clocks
    chk({8'h00, b}, 16'h0015);
    // Down count with trigger held low: 8,7,6,5, wrap to FFFF, 18 more
    wr(3'h5, 8'h01);
    wr(3'h3, 8'h05);
    wr(3'h4, 8'h00);
    wr(3'h1, 8'h08);
    wr(3'h2, 8'h00);
    go_trig <= 1'b1;
    wr(3'h0, 8'h04);
    repeat (40) @(posedge ref_clk);
    rd(3'h0, b);
    chk({8'h00, b}, 16'h0084);
    chk(16'(timer_irq), 16'h0001);
    wr(3'h0, 8'h00);
    go_trig <= 1'b0;
    rd(3'h1, b);
    chk({8'h00, b}, 16'h00ED);
    rd(3'h2, b);
    chk({8'h00, b}, 16'h00FF);
    print_verdict();
  end
endmodule
